// ---- lab_device.sv ----
// Transceiver end: auto-baud, wake on break, break send and detect
// What this block does
// RQ1: Receive edges time the sync character period
// RQ2: Autobaud enable starts calibration, receiver idles
// RQ3: Fifth edge stores count, clears enable, flags
// RQ4: Reading receive data clears receive flag
// RQ5: Rate count pair is one 16-bit counter
// RQ6: Calibration counts at one eighth base clock
// RQ7: Counter starts at one; software subtracts one
// RQ8: Wake plus autobaud measures byte after break
// RQ9: Overflow sets flag, counting runs to fifth
// RQ10: Overflow clear refused while autobaud still enabled
// RQ11: Wake enable idles receiver, watches falling edge
// RQ12: Falling edge in wake sets receive flag
// RQ13: Rising edge ends break, clears wake enable
// RQ14: Nonzero character's first low counts as wake
// RQ15: Remote wake character is long all-zero
// RQ16: Software checks receiver idle before wake enable
// RQ17: Break is start, twelve zeros, stop
// RQ18: Break armed, next data write sends zeros
// RQ19: Break end clears request, buffered byte follows
// RQ20: Shift status covers break like normal frames
// RQ21: Break seen as flag, framing error, zero
// RQ22: Buffer empty flag allows next data write
// RQ23: Receive line synchronised before edge detection
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module lab_device (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    lab_link_if.dev LINK
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAKE, RX_ABD_START, RX_ABD_COUNT
    } lab_rx_state_t;

    lab_rx_state_t st_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic autobaud_enable_q, wake_on_break_enable_q, send_break_request_q, transmit_enable_q;
    logic wide_rate_select_q, high_rate_select_q;
    logic receive_flag_q, autobaud_overflow_flag_q, framing_error_flag_q;
    logic [7:0] rxdata_q, rsh_q;
    logic [15:0] rate_q, rcnt_q, tcnt_q;
    logic [2:0] edges_q;
    logic [3:0] rbits_q, tleft_q;
    logic [9:0] pre_q, div, div_eff;
    logic s1_q, s2_q, s3_q, rx_q, prev_q;
    logic [7:0] buf_q;
    logic buf_full_q, buf_brk_q, tbrk_q, txd_q;
    logic [13:0] tsh_q;
    logic wr, rd, tick, rstb, tstb, fall, rise, load;
    logic ev_byte, ev_wake_fall, ev_wake_rise, ev_abd_done, ev_ovf, ev_brk_done;
    logic [31:0] rmux;

    // Bus slave: one wait cycle, then completes
    assign wr = AVS_WRITE && !wait_q;
    assign rd = AVS_READ && !wait_q;
    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            wait_q <= 1'b1;
        end else if (CE) begin
            wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
        end
    end

    always_comb begin
        rmux = 32'h0000_0000;
        case (AVS_ADDRESS)
            lab_pkg::ADDR_CTRL: begin
                rmux[5:0] = {high_rate_select_q, wide_rate_select_q, transmit_enable_q,
                             send_break_request_q, wake_on_break_enable_q, autobaud_enable_q};
            end
            lab_pkg::ADDR_STAT: begin
                rmux[lab_pkg::SB_RXF] = receive_flag_q;
                rmux[lab_pkg::SB_OVF] = autobaud_overflow_flag_q;
                rmux[lab_pkg::SB_FRAMING_ERROR_FLAG] = framing_error_flag_q;
                // RQ20 shift status
                rmux[lab_pkg::SB_SHIFT_IDLE] = (tleft_q == 4'h0);
                // RQ22 buffer empty
                rmux[lab_pkg::SB_TXE] = !buf_full_q;
                rmux[lab_pkg::SB_RX_IDLE] = (st_q == RX_IDLE);
            end
            lab_pkg::ADDR_RXD: rmux[7:0] = rxdata_q;
            lab_pkg::ADDR_RATE: rmux[15:0] = rate_q;
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            rdata_q <= 32'h0000_0000;
        end else if (CE && AVS_READ && wait_q) begin
            rdata_q <= rmux;
        end
    end

    // RQ23 three-stage line sync
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rx_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (CE) begin
            s1_q <= LINK.rx_line;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                rx_q <= s3_q;
            end
            prev_q <= rx_q;
        end
    end
    assign fall = prev_q && !rx_q;
    assign rise = !prev_q && rx_q;

    // RQ6 base clock select, slowed eightfold in calibration
    always_comb begin
        if (wide_rate_select_q && high_rate_select_q) begin
            div = lab_pkg::DIV_FAST;
        end else if (wide_rate_select_q || high_rate_select_q) begin
            div = lab_pkg::DIV_MID;
        end else begin
            div = lab_pkg::DIV_SLOW;
        end
        div_eff = (st_q == RX_ABD_COUNT) ? (div << lab_pkg::ABD_SHIFT) : div;
    end
    // Compare high: leaving calibration shrinks the divider below the prescaler count
    assign tick = (pre_q >= div_eff - 10'h001);

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            pre_q <= 10'h000;
        end else if (CE) begin
            pre_q <= tick ? 10'h000 : pre_q + 10'h001;
        end
    end

    assign rstb = tick && (rcnt_q == 16'h0000);
    assign tstb = tick && (tcnt_q == 16'h0000);
    // RQ12 wake falling edge
    assign ev_wake_fall = (st_q == RX_WAKE) && fall;
    // RQ13 wake ends on rise
    assign ev_wake_rise = (st_q == RX_WAKE) && rise;
    // RQ3 fifth rising edge
    assign ev_abd_done = (st_q == RX_ABD_COUNT) && rise && (edges_q == lab_pkg::ABD_LAST_EDGE - 3'h1);
    // RQ9 counter wrap
    assign ev_ovf = (st_q == RX_ABD_COUNT) && tick && (rate_q == lab_pkg::RATE_MAX);
    assign ev_byte = (st_q == RX_STOP) && rstb;

    // Receiver sequencer
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            st_q <= RX_IDLE;
            rsh_q <= 8'h00;
            rbits_q <= 4'h0;
            rcnt_q <= 16'h0000;
            edges_q <= 3'h0;
        end else if (CE) begin
            if (tick) begin
                rcnt_q <= (rcnt_q == 16'h0000) ? rate_q : rcnt_q - 16'h0001;
            end
            case (st_q)
                RX_IDLE: begin
                    // RQ11 wake keeps normal reception off
                    if (wake_on_break_enable_q) begin
                        st_q <= RX_WAKE;
                    // RQ2 calibration holds receiver idle
                    end else if (autobaud_enable_q) begin
                        st_q <= RX_ABD_START;
                    end else if (fall) begin
                        st_q <= RX_START;
                        rcnt_q <= rate_q >> 1;
                    end
                end
                RX_START: begin
                    if (rstb) begin
                        st_q <= rx_q ? RX_IDLE : RX_DATA;
                        rbits_q <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rstb) begin
                        rsh_q <= {rx_q, rsh_q[7:1]};
                        rbits_q <= rbits_q + 4'h1;
                        if (rbits_q == lab_pkg::DATA_LAST) begin
                            st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rstb) begin
                        st_q <= RX_IDLE;
                    end
                end
                RX_WAKE: begin
                    // RQ14 any first low-to-high ends the wake
                    // RQ8 idle then picks up a pending calibration
                    if (rise || !wake_on_break_enable_q) begin
                        st_q <= RX_IDLE;
                    end
                end
                RX_ABD_START: begin
                    if (!autobaud_enable_q) begin
                        st_q <= RX_IDLE;
                    // RQ1 counting opens on first rise
                    end else if (rise) begin
                        st_q <= RX_ABD_COUNT;
                        edges_q <= 3'h1;
                    end
                end
                RX_ABD_COUNT: begin
                    if (!autobaud_enable_q || ev_abd_done) begin
                        st_q <= RX_IDLE;
                    end else if (rise) begin
                        edges_q <= edges_q + 3'h1;
                    end
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end

    // RQ5 rate pair counts as one word
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            rate_q <= lab_pkg::RATE_RESET;
        end else if (CE) begin
            if (wr && AVS_ADDRESS == lab_pkg::ADDR_RATE) begin
                rate_q <= AVS_WRITEDATA[15:0];
            // RQ7 count begins at one
            end else if (st_q == RX_ABD_START && autobaud_enable_q && rise) begin
                rate_q <= lab_pkg::ABD_FIRST;
            end else if (st_q == RX_ABD_COUNT && tick && !ev_abd_done) begin
                rate_q <= rate_q + 16'h0001;
            end
        end
    end

    // Control bits; a software write beats a hardware clear
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            {high_rate_select_q, wide_rate_select_q, transmit_enable_q, send_break_request_q,
             wake_on_break_enable_q, autobaud_enable_q} <= lab_pkg::CTRL_RESET;
        end else if (CE) begin
            if (wr && AVS_ADDRESS == lab_pkg::ADDR_CTRL) begin
                {high_rate_select_q, wide_rate_select_q, transmit_enable_q, send_break_request_q,
                 wake_on_break_enable_q, autobaud_enable_q} <= AVS_WRITEDATA[5:0];
            end else begin
                // RQ3 enable self-clears
                if (ev_abd_done) begin
                    autobaud_enable_q <= 1'b0;
                end
                // RQ13 wake enable self-clears
                if (ev_wake_rise) begin
                    wake_on_break_enable_q <= 1'b0;
                end
                // RQ19 break request self-clears
                if (ev_brk_done) begin
                    send_break_request_q <= 1'b0;
                end
            end
        end
    end

    // Status flags: hardware set wins over clear
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            receive_flag_q <= 1'b0;
            autobaud_overflow_flag_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            rxdata_q <= 8'h00;
        end else if (CE) begin
            // RQ12 flag on wake, byte or calibration end
            if (ev_byte || ev_wake_fall || ev_abd_done) begin
                receive_flag_q <= 1'b1;
            // RQ4 data read clears flag
            end else if (rd && AVS_ADDRESS == lab_pkg::ADDR_RXD) begin
                receive_flag_q <= 1'b0;
            end
            if (ev_ovf) begin
                autobaud_overflow_flag_q <= 1'b1;
            // RQ10 clear refused while calibrating
            end else if (wr && AVS_ADDRESS == lab_pkg::ADDR_STAT && AVS_WRITEDATA[lab_pkg::SB_OVF]
                         && !autobaud_enable_q) begin
                autobaud_overflow_flag_q <= 1'b0;
            end
            // RQ21 zero data with framing error marks break
            if (ev_byte) begin
                rxdata_q <= rsh_q;
                framing_error_flag_q <= !rx_q;
            end
        end
    end

    // Transmit buffer and shifter
    // Frames start on a tick, else the start bit comes up short
    assign load = (tleft_q == 4'h0) && buf_full_q && transmit_enable_q && tick;
    assign ev_brk_done = tstb && tbrk_q && (tleft_q == 4'h1);
    assign LINK.tx_line = txd_q;

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            buf_q <= 8'h00;
            buf_full_q <= 1'b0;
            buf_brk_q <= 1'b0;
        end else if (CE) begin
            if (wr && AVS_ADDRESS == lab_pkg::ADDR_TXD && !buf_full_q) begin
                buf_q <= AVS_WRITEDATA[7:0];
                buf_full_q <= 1'b1;
                // RQ18 only the first write after arming is a break
                buf_brk_q <= send_break_request_q && transmit_enable_q && !tbrk_q;
            end else if (load) begin
                buf_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            tsh_q <= 14'h0000;
            tleft_q <= 4'h0;
            tcnt_q <= 16'h0000;
            tbrk_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (CE) begin
            if (load) begin
                txd_q <= 1'b0;
                tcnt_q <= rate_q;
                tbrk_q <= buf_brk_q;
                // RQ17 break frame shape, data ignored
                tsh_q <= buf_brk_q ? lab_pkg::BREAK_TAIL : {5'h01, buf_q, 1'b0} >> 1;
                tleft_q <= buf_brk_q ? lab_pkg::LEN_BREAK : lab_pkg::LEN_BYTE;
            end else if (tleft_q != 4'h0 && tick) begin
                tcnt_q <= (tcnt_q == 16'h0000) ? rate_q : tcnt_q - 16'h0001;
                if (tstb) begin
                    tleft_q <= tleft_q - 4'h1;
                    txd_q <= (tleft_q == 4'h1) ? 1'b1 : tsh_q[0];
                    tsh_q <= tsh_q >> 1;
                    if (tleft_q == 4'h1) begin
                        tbrk_q <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : lab_device

// ---- lab_pkg.sv ----
// Shared constants for the LIN auto-baud and break logic
package lab_pkg;
    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h04;
    localparam logic [4:0] ADDR_RXD = 5'h08;
    localparam logic [4:0] ADDR_TXD = 5'h0C;
    localparam logic [4:0] ADDR_RATE = 5'h10;
    // Control register fields
    localparam int CB_AUTOBAUD = 0;
    localparam int CB_WAKE = 1;
    localparam int CB_BREAK = 2;
    localparam int CB_TRANSMIT_ENABLE = 3;
    localparam int CB_WIDE = 4;
    localparam int CB_HIGH = 5;
    // Status register fields
    localparam int SB_RXF = 0;
    localparam int SB_OVF = 1;
    localparam int SB_FRAMING_ERROR_FLAG = 2;
    localparam int SB_SHIFT_IDLE = 3;
    localparam int SB_TXE = 4;
    localparam int SB_RX_IDLE = 5;
    // Reset values, rate counter limit and calibration start count
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [15:0] RATE_RESET = 16'h0000;
    localparam logic [15:0] RATE_MAX = 16'hFFFF;
    localparam logic [15:0] ABD_FIRST = 16'h0001;
    // Base clock dividers and the auto-baud slow-down shift
    localparam logic [9:0] DIV_FAST = 10'h004;
    localparam logic [9:0] DIV_MID = 10'h010;
    localparam logic [9:0] DIV_SLOW = 10'h040;
    localparam int ABD_SHIFT = 3;
    // Rising edges of the sync character
    localparam logic [2:0] ABD_LAST_EDGE = 3'h5;
    // Frame shapes; lengths count the start bit, the tail follows it
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] LEN_BYTE = 4'hA;
    localparam logic [3:0] LEN_BREAK = 4'hE;
    localparam logic [13:0] BREAK_TAIL = 14'h1000;
endpackage : lab_pkg

// ---- lab_link_if.sv ----
// Serial lines between the transceiver and the remote node
`timescale 1ns/10ps
interface lab_link_if;
    logic rx_line;
    logic tx_line;
    modport dev (input rx_line, output tx_line);
    modport node (output rx_line, input tx_line);
endinterface : lab_link_if

// ---- lab_node.sv ----
// Remote serial node: sends breaks and bytes, receives bytes
`timescale 1ns/10ps
module lab_node (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic [15:0] BIT_CYCLES,
    input wire logic SEND_BREAK,
    input wire logic SEND_BYTE,
    input wire logic [7:0] TX_BYTE,
    output logic TX_BUSY,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic RX_FRAME_ERR,
    lab_link_if.node LINK
);
    logic [15:0] tcnt_q, rcnt_q;
    logic [13:0] tsh_q;
    logic [3:0] tleft_q, rbits_q;
    logic txd_q, s1_q, s2_q, s3_q, rx_q, prev_q, rbusy_q;
    logic [8:0] rsh_q;
    logic tstb, rstb;

    assign LINK.rx_line = txd_q;
    assign TX_BUSY = (tleft_q != 4'h0);
    assign tstb = (tcnt_q == 16'h0000);
    assign rstb = (rcnt_q == 16'h0000);

    // Break is thirteen low bit times, well above the minimum of ten
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            tcnt_q <= 16'h0000;
            tsh_q <= 14'h0000;
            tleft_q <= 4'h0;
            txd_q <= 1'b1;
        end else if (CE) begin
            if (tleft_q == 4'h0) begin
                if (SEND_BREAK || SEND_BYTE) begin
                    txd_q <= 1'b0;
                    tcnt_q <= BIT_CYCLES - 16'h0001;
                    tsh_q <= SEND_BREAK ? lab_pkg::BREAK_TAIL : {5'h01, TX_BYTE, 1'b0} >> 1;
                    tleft_q <= SEND_BREAK ? lab_pkg::LEN_BREAK : lab_pkg::LEN_BYTE;
                end
            end else if (tstb) begin
                tcnt_q <= BIT_CYCLES - 16'h0001;
                tleft_q <= tleft_q - 4'h1;
                txd_q <= (tleft_q == 4'h1) ? 1'b1 : tsh_q[0];
                tsh_q <= tsh_q >> 1;
            end else begin
                tcnt_q <= tcnt_q - 16'h0001;
            end
        end
    end

    // Line sync; the first stage feeds only the second
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rx_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (CE) begin
            s1_q <= LINK.tx_line;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                rx_q <= s3_q;
            end
            prev_q <= rx_q;
        end
    end

    // Receiver samples mid-bit: start, eight data, stop
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            rbusy_q <= 1'b0;
            rcnt_q <= 16'h0000;
            rbits_q <= 4'h0;
            rsh_q <= 9'h000;
            RX_BYTE <= 8'h00;
            RX_VALID <= 1'b0;
            RX_FRAME_ERR <= 1'b0;
        end else if (CE) begin
            RX_VALID <= 1'b0;
            if (!rbusy_q) begin
                if (prev_q && !rx_q) begin
                    rbusy_q <= 1'b1;
                    rcnt_q <= BIT_CYCLES >> 1;
                    rbits_q <= 4'h0;
                end
            end else if (rstb) begin
                rcnt_q <= BIT_CYCLES - 16'h0001;
                rbits_q <= rbits_q + 4'h1;
                rsh_q <= {rx_q, rsh_q[8:1]};
                if (rbits_q == 4'h0 && rx_q) begin
                    rbusy_q <= 1'b0;
                end else if (rbits_q == lab_pkg::LEN_BYTE - 4'h1) begin
                    rbusy_q <= 1'b0;
                    RX_BYTE <= rsh_q[8:1];
                    RX_FRAME_ERR <= !rx_q;
                    RX_VALID <= 1'b1;
                end
            end else begin
                rcnt_q <= rcnt_q - 16'h0001;
            end
        end
    end
endmodule : lab_node

// ---- lab_assertions.sv ----
// Wire checks on the serial link between transceiver and node
`timescale 1ns/10ps
module lab_assertions (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic rx_line,
    input wire logic tx_line
);
    logic [7:0] tlow_q;
    logic [7:0] thigh_q;
    logic [7:0] rlow_q;
    // Run lengths; the bench runs link bits at 8 cycles, sync bytes at 64 or 256
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N || tx_line) tlow_q <= 8'h00;
        else tlow_q <= tlow_q + 8'h01;
    end
    // Saturates so a long idle cannot wrap to a short run
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N || !tx_line) thigh_q <= 8'h00;
        else if (thigh_q != 8'hFF) thigh_q <= thigh_q + 8'h01;
    end
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N || rx_line) rlow_q <= 8'h00;
        else rlow_q <= rlow_q + 8'h01;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    chk_lines_idle_reset: assert property ($rose(RESET_N) |-> tx_line && rx_line)
        else $error("link lines not idle high after reset");
    chk_tx_low_max: assert property (tlow_q <= 8'h68)
        else $error("tx low longer than a break");
    chk_tx_whole_bits: assert property ($rose(tx_line) |-> tlow_q[2:0] == 3'h0)
        else $error("tx low run not whole bits");
    chk_tx_break_len: assert property ($rose(tx_line) && tlow_q > 8'h48 |-> tlow_q == 8'h68)
        else $error("tx break not thirteen low bits");
    chk_tx_stop_high: assert property ($rose(tx_line) |-> tx_line[*8])
        else $error("tx high shorter than a bit");
    chk_tx_high_min: assert property ($fell(tx_line) |-> thigh_q >= 8'h08)
        else $error("tx falls before a full high bit");
    chk_rx_whole_bits: assert property ($rose(rx_line) |-> rlow_q[2:0] == 3'h0)
        else $error("rx low run not whole bits");
    chk_rx_stop_high: assert property ($rose(rx_line) |-> rx_line[*8])
        else $error("rx high shorter than a bit");
    cover property ($rose(tx_line) && tlow_q == 8'h68);
    cover property ($rose(rx_line) && rlow_q == 8'h68);
    cover property ($rose(tx_line) && tlow_q == 8'h08);
endmodule : lab_assertions

// ---- lin_autobaud_break_logic_tb.sv ----
// Self-checking bench: transceiver and node joined over the link
`timescale 1ns/10ps
module lin_autobaud_break_logic_tb;
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic wreq;
    logic [15:0] bitc = 16'h0008;
    logic sbrk = 1'b0;
    logic sbyt = 1'b0;
    logic [7:0] txb = 8'h00;
    logic busy;
    logic [7:0] rxb;
    logic rxv;
    logic rxfe;
    logic [31:0] q;
    int num_errors = 0;
    int checks = 0;
    int e;
    logic [7:0] cf [3] = '{8'h39, 8'h29, 8'h3B};
    int nb [3] = '{64, 256, 64};
    int dv [3] = '{4, 16, 4};
    lab_link_if lab_link_if_inst ();
    lab_device lab_device_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CE(1'b1), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .LINK(lab_link_if_inst.dev));
    lab_node lab_node_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CE(1'b1), .BIT_CYCLES(bitc),
        .SEND_BREAK(sbrk), .SEND_BYTE(sbyt), .TX_BYTE(txb), .TX_BUSY(busy), .RX_BYTE(rxb),
        .RX_VALID(rxv), .RX_FRAME_ERR(rxfe), .LINK(lab_link_if_inst.node));
    lab_assertions lab_assertions_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
        .rx_line(lab_link_if_inst.rx_line), .tx_line(lab_link_if_inst.tx_line));
    always #50 CLK_SYS = ~CLK_SYS;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic fail_wait();
        num_errors++;
        $display("MISMATCH wait expected done seen timeout");
        end_of_test();
    endtask : fail_wait
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) fail_wait();
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge CLK_SYS);
    endtask : bus
    task automatic rc(input logic [4:0] a, input logic [31:0] x, input string nm);
        bus(1'b0, a, 32'h00000000);
        chk(nm, x, q);
    endtask : rc
    task automatic wait_stat(input int b);
        for (int n = 0; n < 2000; n++) begin
            bus(1'b0, lab_pkg::ADDR_STAT, 32'h00000000);
            if (q[b] === 1'b1) return;
        end
        fail_wait();
    endtask : wait_stat
    task automatic wait_idle();
        for (int n = 0; n < 5000; n++) begin
            if (busy === 1'b0) return;
            @(posedge CLK_SYS);
        end
        fail_wait();
    endtask : wait_idle
    // The first edge brings the node's busy flag up
    task automatic send(input logic b, input logic [7:0] v);
        sbrk <= b;
        sbyt <= !b;
        txb <= v;
        @(posedge CLK_SYS);
        sbrk <= 1'b0;
        sbyt <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
    endtask : send
    task automatic wait_rx(input logic [7:0] v, input logic fe);
        for (int n = 0; rxv !== 1'b1; n++) begin
            if (n > 3000) fail_wait();
            @(posedge CLK_SYS);
        end
        chk("node byte", {24'h0, v}, {24'h0, rxb});
        chk("node framing", {31'h0, fe}, {31'h0, rxfe});
        @(posedge CLK_SYS);
    endtask : wait_rx
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        @(posedge CLK_SYS);
        rc(lab_pkg::ADDR_CTRL, 32'h00000000, "ctrl reset");
        rc(lab_pkg::ADDR_RATE, 32'h00000000, "rate reset");
        rc(lab_pkg::ADDR_STAT, 32'h00000038, "stat reset");
        bus(1'b1, 5'h14, 32'hFFFFFFFF);
        rc(5'h14, 32'h00000000, "unmapped");
        bus(1'b1, lab_pkg::ADDR_RATE, 32'h00000001);
        bus(1'b1, lab_pkg::ADDR_CTRL, 32'h0000003C);
        bus(1'b1, lab_pkg::ADDR_TXD, 32'h000000A5);
        // Break loads on the next rate tick, so poll
        wait_stat(lab_pkg::SB_TXE);
        chk("shift busy buffer free", 32'h10, q & 32'h18);
        bus(1'b1, lab_pkg::ADDR_TXD, 32'h00000055);
        bus(1'b0, lab_pkg::ADDR_STAT, 32'h00000000);
        chk("buffer full", 32'h0, q & 32'h10);
        wait_rx(8'h00, 1'b1);
        wait_rx(8'h55, 1'b0);
        rc(lab_pkg::ADDR_CTRL, 32'h00000038, "break request");
        wait_stat(lab_pkg::SB_SHIFT_IDLE);
        // Node break seen by the device as a zero with a framing error
        send(1'b1, 8'h00);
        wait_stat(lab_pkg::SB_RXF);
        chk("break flags", 32'h5, q & 32'h5);
        rc(lab_pkg::ADDR_RXD, 32'h00000000, "break data");
        wait_idle();
        bus(1'b0, lab_pkg::ADDR_STAT, 32'h00000000);
        chk("receiver idle", 32'h20, q & 32'h21);
        bus(1'b1, lab_pkg::ADDR_CTRL, 32'h0000003A);
        send(1'b1, 8'h00);
        wait_stat(lab_pkg::SB_RXF);
        rc(lab_pkg::ADDR_CTRL, 32'h0000003A, "wake held");
        bus(1'b0, lab_pkg::ADDR_RXD, 32'h00000000);
        wait_idle();
        rc(lab_pkg::ADDR_CTRL, 32'h00000038, "wake cleared");
        bus(1'b0, lab_pkg::ADDR_STAT, 32'h00000000);
        chk("no frame in wake", 32'h0, q & 32'h1);
        // Sync byte timing, with and without a wake break first
        for (int i = 0; i < 3; i++) begin
            bitc <= 16'h0008;
            bus(1'b1, lab_pkg::ADDR_CTRL, {24'h0, cf[i]});
            if (cf[i][1]) begin
                send(1'b1, 8'h00);
                wait_idle();
                bus(1'b0, lab_pkg::ADDR_RXD, 32'h00000000);
            end
            bitc <= nb[i][15:0];
            send(1'b0, 8'h55);
            wait_stat(lab_pkg::SB_RXF);
            rc(lab_pkg::ADDR_CTRL, {24'h0, cf[i] & 8'h3C}, "enables cleared");
            bus(1'b0, lab_pkg::ADDR_RATE, 32'h00000000);
            // One count per bit in base ticks, plus the starting one
            e = nb[i] / dv[i] + 1;
            chk("rate count", 32'h1, {31'h0, q >= e - 1 && q <= e + 1});
            bus(1'b0, lab_pkg::ADDR_RXD, 32'h00000000);
            bus(1'b0, lab_pkg::ADDR_STAT, 32'h00000000);
            chk("flags clear", 32'h0, q & 32'h3);
            wait_idle();
        end
        end_of_test();
    end
endmodule : lin_autobaud_break_logic_tb
